// ### hw/rtu_pkg.sv
// constants for the unsigned remote result and offset correction block
package rtu_pkg;
  // ---------------------------------------------------------------
  // command bytes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_R1_INT = 8'h19;
  localparam logic [7:0] CMD_R2_INT = 8'h1a;
  localparam logic [7:0] CMD_R1_FRAC = 8'h29;
  localparam logic [7:0] CMD_R2_FRAC = 8'h2a;
  localparam logic [7:0] CMD_R1_OFS = 8'h31;
  localparam logic [7:0] CMD_R2_OFS = 8'h32;
  // ---------------------------------------------------------------
  // reset values and field layout
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_RESET = 8'h00;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam int RAW_WIDTH = 13;     // 8 integer, 5 fraction bits (1/32 degree)
  localparam int FRAC_KEEP = 3;      // fraction bits always shown
  localparam int FRAC_FILT = 2;      // extra bits shown with filter on
  localparam logic [1:0] FILT_OFF = 2'h0;
  localparam logic [1:0] FILT_BASIC = 2'h1;
  localparam logic [1:0] FILT_RSVD = 2'h2;
  localparam logic [1:0] FILT_ENH = 2'h3;
endpackage : rtu_pkg

// ### hw/rtu_result.sv
// remote channel unsigned result formatting, offset correction and fraction lock
// ---------------------------------------------------------------
// Functional notes
// - integer byte unsigned, bit7 128 down to 1
// - fraction byte bits 7..5 half, quarter, eighth
// - fraction bit4 sixteenth only with filter on
// - fraction bit3 thirty-second only with filter on
// - fraction bits 2..0 always read zero
// - writable two's complement offset per channel
// - offset spans minus 64 to plus 63.5
// - corrected sum stored, not raw value
// - integer read locks fraction until fraction read
// - filter selector 00 off, 01/11 on, 10 reserved
// ---------------------------------------------------------------
`timescale 1ns/1ps
module rtu_result
  import rtu_pkg::*;
#(
  parameter int CHANNELS = 2
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // converter side, one raw reading per channel in 1/32 degree steps
  input wire logic [CHANNELS-1:0] conv_done,
  input wire logic [CHANNELS*RAW_WIDTH-1:0] conv_raw,
  // filter selection from the configuration unit
  input wire logic [1:0] remote_one_filter_select,
  input wire logic [1:0] remote_two_filter_select,
  // command port from the bus engine
  input wire logic [7:0] cmd_addr,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic [7:0] cmd_wdata,
  output logic [7:0] cmd_rdata,
  output logic cmd_rvalid
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0] ofs [CHANNELS];
  logic [7:0] res_int [CHANNELS];
  logic [4:0] res_frac [CHANNELS];
  logic [4:0] lock_frac [CHANNELS];
  logic [CHANNELS-1:0] locked;
  logic [7:0] next_ofs [CHANNELS];
  logic [7:0] next_res_int [CHANNELS];
  logic [4:0] next_res_frac [CHANNELS];
  logic [4:0] next_lock_frac [CHANNELS];
  logic [CHANNELS-1:0] next_locked;
  logic [7:0] next_cmd_rdata;
  logic next_cmd_rvalid;
  logic [1:0] fsel [CHANNELS];
  logic [CHANNELS-1:0] filt_on;
  logic [CHANNELS-1:0] rd_int;
  logic [CHANNELS-1:0] rd_frac;
  logic [CHANNELS-1:0] wr_ofs;

  // gather the per channel selectors so the generate loop can index them
  assign fsel[0] = remote_one_filter_select;
  assign fsel[1] = remote_two_filter_select;

  // ---------------------------------------------------------------
  // per channel datapath
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++)
    begin : g_ch
      logic [RAW_WIDTH:0] sum;
      logic [RAW_WIDTH-1:0] corr;
      logic [7:0] int_cmd;
      logic [7:0] frac_cmd;
      logic [7:0] ofs_cmd;
      assign int_cmd = (g == 0) ? CMD_R1_INT : CMD_R2_INT;
      assign frac_cmd = (g == 0) ? CMD_R1_FRAC : CMD_R2_FRAC;
      assign ofs_cmd = (g == 0) ? CMD_R1_OFS : CMD_R2_OFS;
      // any enabled code counts as on; reserved code treated as off
      assign filt_on[g] = (fsel[g] == FILT_BASIC) || (fsel[g] == FILT_ENH);
      assign rd_int[g] = cmd_rd && (cmd_addr == int_cmd);
      assign rd_frac[g] = cmd_rd && (cmd_addr == frac_cmd);
      assign wr_ofs[g] = cmd_wr && (cmd_addr == ofs_cmd);
      // offset in half degrees, sign extended to 1/32 steps (shift by 4)
      // offset byte 8 bits signed covers -64..+63.5
      always_comb
      begin
        sum = {1'b0, conv_raw[g*RAW_WIDTH +: RAW_WIDTH]}
            + {{2{ofs[g][7]}}, ofs[g], 4'h0};
        // clamp rather than wrap; a set top bit means underflow for a
        // negative offset and overflow for a positive one
        if (sum[RAW_WIDTH] && ofs[g][7])
          corr = '0;
        else if (sum[RAW_WIDTH])
          corr = '1;
        else
          corr = sum[RAW_WIDTH-1:0];
      end
      // next offset, result pair and lock state of this channel
      always_comb
      begin
        next_ofs[g] = ofs[g];
        next_res_int[g] = res_int[g];
        next_res_frac[g] = res_frac[g];
        next_lock_frac[g] = lock_frac[g];
        next_locked[g] = locked[g];
        if (wr_ofs[g])
          next_ofs[g] = cmd_wdata;
        // both bytes from one corrected sample
        if (conv_done[g])
        begin
          next_res_int[g] = corr[RAW_WIDTH-1 -: 8];
          next_res_frac[g] = corr[4:0];
        end
        // a fraction read unlocks; a later integer read relocks with the new value
        if (rd_frac[g])
          next_locked[g] = 1'b0;
        if (rd_int[g])
        begin
          next_locked[g] = 1'b1;
          next_lock_frac[g] = res_frac[g];
        end
      end
      // channel registers, reset clears offset, results and lock
      always_ff @(posedge ref_clk or negedge resetn)
      begin
        if (!resetn)
        begin
          ofs[g] <= OFS_RESET;
          res_int[g] <= RESULT_RESET;
          res_frac[g] <= RESULT_RESET[4:0];
          lock_frac[g] <= RESULT_RESET[4:0];
          locked[g] <= 1'b0;
        end
        else
        begin
          ofs[g] <= next_ofs[g];
          res_int[g] <= next_res_int[g];
          res_frac[g] <= next_res_frac[g];
          lock_frac[g] <= next_lock_frac[g];
          locked[g] <= next_locked[g];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // fraction byte formatting
  // ---------------------------------------------------------------
  function automatic logic [7:0] fmt_frac(input logic [4:0] f, input logic on);
    fmt_frac = {f[4:2], on ? f[1:0] : 2'h0, 3'h0};
  endfunction

  // ---------------------------------------------------------------
  // read decode, one cycle after the read strobe
  // ---------------------------------------------------------------
  always_comb
  begin
    next_cmd_rvalid = cmd_rd;
    next_cmd_rdata = UNMAPPED_READ;
    if (!cmd_rd)
      next_cmd_rdata = cmd_rdata;
    else if (cmd_addr == CMD_R1_INT)
      next_cmd_rdata = res_int[0];
    else if (cmd_addr == CMD_R2_INT)
      next_cmd_rdata = res_int[1];
    else if (cmd_addr == CMD_R1_FRAC)
      next_cmd_rdata = fmt_frac(locked[0] ? lock_frac[0] : res_frac[0], filt_on[0]);
    else if (cmd_addr == CMD_R2_FRAC)
      next_cmd_rdata = fmt_frac(locked[1] ? lock_frac[1] : res_frac[1], filt_on[1]);
    else if (cmd_addr == CMD_R1_OFS)
      next_cmd_rdata = ofs[0];
    else if (cmd_addr == CMD_R2_OFS)
      next_cmd_rdata = ofs[1];
  end

  // read answer registered so both outputs come straight from flops
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cmd_rdata <= UNMAPPED_READ;
      cmd_rvalid <= 1'b0;
    end
    else
    begin
      cmd_rdata <= next_cmd_rdata;
      cmd_rvalid <= next_cmd_rvalid;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  // read answer timing; the bus engine relies on a single answer cycle
  a_rvalid_follows: assert property (@(posedge ref_clk) disable iff (!resetn)
    cmd_rd |=> cmd_rvalid)
    else $error("read answer missing");
  a_rvalid_pulse: assert property (@(posedge ref_clk) disable iff (!resetn)
    !cmd_rd |=> !cmd_rvalid)
    else $error("read answer without a read");
  a_rdata_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
    !cmd_rd |=> $stable(cmd_rdata))
    else $error("read data moved without a read");

  // integer bytes return the stored corrected byte unchanged
  a_int_read_one: assert property (@(posedge ref_clk) disable iff (!resetn)
    (cmd_rd && cmd_addr == CMD_R1_INT) |=> cmd_rdata == $past(res_int[0]))
    else $error("integer one read wrong");
  a_int_read_two: assert property (@(posedge ref_clk) disable iff (!resetn)
    (cmd_rd && cmd_addr == CMD_R2_INT) |=> cmd_rdata == $past(res_int[1]))
    else $error("integer two read wrong");

  // fraction byte layout
  a_frac_low_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
    cmd_rvalid |-> ($past(cmd_addr) != CMD_R1_FRAC && $past(cmd_addr) != CMD_R2_FRAC)
    || cmd_rdata[2:0] == 3'h0)
    else $error("reserved fraction bits set");
  a_frac_high_one: assert property (@(posedge ref_clk) disable iff (!resetn)
    (cmd_rd && cmd_addr == CMD_R1_FRAC && !locked[0])
    |=> cmd_rdata[7:5] == $past(res_frac[0][4:2])) else $error("fraction top bits wrong");
  a_filt_off_one: assert property (@(posedge ref_clk) disable iff (!resetn)
    (cmd_rd && cmd_addr == CMD_R1_FRAC && !filt_on[0]) |=> cmd_rdata[4:3] == 2'h0)
    else $error("filter bits shown with filter off");
  a_filt_off_two: assert property (@(posedge ref_clk) disable iff (!resetn)
    (cmd_rd && cmd_addr == CMD_R2_FRAC && !filt_on[1]) |=> cmd_rdata[4:3] == 2'h0)
    else $error("filter bits shown with filter off");
  a_filt_on_one: assert property (@(posedge ref_clk) disable iff (!resetn)
    (cmd_rd && cmd_addr == CMD_R1_FRAC && filt_on[0] && !locked[0])
    |=> cmd_rdata[4:3] == $past(res_frac[0][1:0])) else $error("filter bits lost");
  a_filt_on_two: assert property (@(posedge ref_clk) disable iff (!resetn)
    (cmd_rd && cmd_addr == CMD_R2_FRAC && filt_on[1] && !locked[1])
    |=> cmd_rdata[4:3] == $past(res_frac[1][1:0])) else $error("filter bits lost");
  a_rsvd_off: assert property (@(posedge ref_clk) disable iff (!resetn)
    (remote_one_filter_select == FILT_RSVD) |-> !filt_on[0])
    else $error("reserved code enabled filter");

  // offset registers
  a_ofs_write: assert property (@(posedge ref_clk) disable iff (!resetn)
    (cmd_wr && cmd_addr == CMD_R1_OFS) |=> ofs[0] == $past(cmd_wdata))
    else $error("offset write lost");
  a_ofs_write_two: assert property (@(posedge ref_clk) disable iff (!resetn)
    (cmd_wr && cmd_addr == CMD_R2_OFS) |=> ofs[1] == $past(cmd_wdata))
    else $error("offset two write lost");
  a_ofs_read_one: assert property (@(posedge ref_clk) disable iff (!resetn)
    (cmd_rd && cmd_addr == CMD_R1_OFS) |=> cmd_rdata == $past(ofs[0]))
    else $error("offset read wrong");

  // fraction lock; both channels have their own lock
  a_lock_held: assert property (@(posedge ref_clk) disable iff (!resetn)
    (locked[0] && !rd_int[0] && !rd_frac[0]) |=> $stable(lock_frac[0]) && locked[0])
    else $error("locked fraction changed");
  a_lock_held_two: assert property (@(posedge ref_clk) disable iff (!resetn)
    (locked[1] && !rd_int[1] && !rd_frac[1]) |=> $stable(lock_frac[1]) && locked[1])
    else $error("locked fraction changed");
  a_lock_take: assert property (@(posedge ref_clk) disable iff (!resetn)
    rd_int[1] |=> locked[1] && lock_frac[1] == $past(res_frac[1]))
    else $error("integer read did not lock");
  a_lock_take_one: assert property (@(posedge ref_clk) disable iff (!resetn)
    rd_int[0] |=> locked[0] && lock_frac[0] == $past(res_frac[0]))
    else $error("integer read did not lock");
  a_unlock_one: assert property (@(posedge ref_clk) disable iff (!resetn)
    rd_frac[0] |=> !locked[0])
    else $error("fraction read did not unlock");
  a_locked_read_one: assert property (@(posedge ref_clk) disable iff (!resetn)
    (cmd_rd && cmd_addr == CMD_R1_FRAC && locked[0])
    |=> cmd_rdata[7:5] == $past(lock_frac[0][4:2])) else $error("locked fraction not shown");

  // result update and offset arithmetic
  a_pair_update: assert property (@(posedge ref_clk) disable iff (!resetn)
    !conv_done[0] |=> $stable(res_int[0]) && $stable(res_frac[0]))
    else $error("result changed without conversion");
  a_pair_update_two: assert property (@(posedge ref_clk) disable iff (!resetn)
    !conv_done[1] |=> $stable(res_int[1]) && $stable(res_frac[1]))
    else $error("result changed without conversion");
  a_offset_sum: assert property (@(posedge ref_clk) disable iff (!resetn)
    (conv_done[0] && ofs[0] == 8'h00) |=> {res_int[0], res_frac[0]}
    == $past(conv_raw[RAW_WIDTH-1:0])) else $error("zero offset altered result");
  a_offset_sum_two: assert property (@(posedge ref_clk) disable iff (!resetn)
    (conv_done[1] && ofs[1] == 8'h00) |=> {res_int[1], res_frac[1]}
    == $past(conv_raw[RAW_WIDTH +: RAW_WIDTH])) else $error("zero offset altered result");
  // with saturation an offset can only move the result in its own direction
  a_ofs_up_one: assert property (@(posedge ref_clk) disable iff (!resetn)
    (conv_done[0] && !ofs[0][7]) |=> {res_int[0], res_frac[0]}
    >= $past(conv_raw[RAW_WIDTH-1:0])) else $error("positive offset lowered result");
  a_ofs_down_two: assert property (@(posedge ref_clk) disable iff (!resetn)
    (conv_done[1] && ofs[1][7]) |=> {res_int[1], res_frac[1]}
    <= $past(conv_raw[RAW_WIDTH +: RAW_WIDTH])) else $error("negative offset raised result");

  // main scenarios
  c_lock_then_read: cover property (@(posedge ref_clk) disable iff (!resetn)
    rd_int[0] ##[1:20] rd_frac[0]);
  c_conv_while_locked: cover property (@(posedge ref_clk) disable iff (!resetn)
    locked[0] && conv_done[0]);
  c_neg_offset: cover property (@(posedge ref_clk) disable iff (!resetn)
    conv_done[1] && ofs[1][7]);
  c_filter_bits_read: cover property (@(posedge ref_clk) disable iff (!resetn)
    rd_frac[1] && filt_on[1]);
  c_offset_zero_conv: cover property (@(posedge ref_clk) disable iff (!resetn)
    conv_done[0] && ofs[0] == 8'h00);

endmodule // rtu_result

// ### sim/rtu_host_model.sv
// bus host model that issues command reads and writes to the block
`timescale 1ns/1ps
module rtu_host_model
(
  // clock
  input wire logic ref_clk,
  // command port toward the block
  output logic [7:0] cmd_addr,
  output logic cmd_wr,
  output logic cmd_rd,
  output logic [7:0] cmd_wdata,
  input wire logic [7:0] cmd_rdata,
  input wire logic cmd_rvalid
);
  initial
  begin
    cmd_addr = 8'h00;
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_wdata = 8'h00;
  end
  // one-cycle write strobe; stale data inverted so it never looks valid
  task automatic wr_cmd(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    cmd_addr = a;
    cmd_wdata = d;
    cmd_wr = 1'b1;
    @(negedge ref_clk);
    cmd_wr = 1'b0;
    cmd_wdata = ~d;
  endtask
  // read; waits up to four cycles for the answer, x if none comes
  task automatic rd_cmd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(negedge ref_clk);
    cmd_addr = a;
    cmd_rd = 1'b1;
    @(negedge ref_clk);
    cmd_rd = 1'b0;
    n = 0;
    while (cmd_rvalid !== 1'b1 && n < 4)
    begin
      @(negedge ref_clk);
      n++;
    end
    d = (n < 4) ? cmd_rdata : 8'hxx;
  endtask
endmodule // rtu_host_model

// ### sim/remote_temp_unsigned_result_offset_test.sv
// self-checking bench for the unsigned remote result block
`timescale 1ns/1ps
module remote_temp_unsigned_result_offset_test;
  import rtu_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn;
  logic [1:0] conv_done;
  logic [25:0] conv_raw;
  logic [1:0] remote_one_filter_select;
  logic [1:0] remote_two_filter_select;
  logic [7:0] cmd_addr, cmd_wdata, cmd_rdata;
  logic cmd_wr, cmd_rd, cmd_rvalid;
  logic [7:0] ofs [2];
  logic [12:0] v0, v1;
  int n_mismatch = 0;
  int total_checks = 0;
  initial
  begin
    forever #20 ref_clk = ~ref_clk;
  end
  rtu_result i_rtu_result (.ref_clk(ref_clk), .resetn(resetn), .conv_done(conv_done),
    .conv_raw(conv_raw), .remote_one_filter_select(remote_one_filter_select),
    .remote_two_filter_select(remote_two_filter_select), .cmd_addr(cmd_addr),
    .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
    .cmd_rvalid(cmd_rvalid));
  rtu_host_model host (.ref_clk(ref_clk), .cmd_addr(cmd_addr), .cmd_wr(cmd_wr),
    .cmd_rd(cmd_rd), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid));
  // ---------------------------------------------------------------
  // expectations and helpers
  // ---------------------------------------------------------------
  // corrected reading, saturated to the 13-bit unsigned range
  function automatic logic [12:0] corr(input logic [12:0] raw, input logic [7:0] o);
    int s;
    s = int'(raw) + 16 * int'($signed(o));
    if (s < 0)
      s = 0;
    else if (s > 8191)
      s = 8191;
    return s[12:0];
  endfunction
  function automatic logic [7:0] frac_of(input logic [12:0] v, input logic [1:0] f);
    return {v[4:2], (f == FILT_BASIC || f == FILT_ENH) ? v[1:0] : 2'h0, 3'h0};
  endfunction
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd_cmd(a, d);
    chk(what, exp, d);
  endtask
  // one conversion pulse with the filter selection held from here on
  task automatic conv(input int ch, input logic [12:0] raw, input logic [1:0] f);
    @(negedge ref_clk);
    if (ch == 0)
      remote_one_filter_select = f;
    else
      remote_two_filter_select = f;
    conv_raw[ch*13+:13] = raw;
    conv_done[ch] = 1'b1;
    @(negedge ref_clk);
    conv_done = 2'h0;
  endtask
  task automatic conv_chk(input int ch, input logic [12:0] raw, input logic [1:0] f);
    logic [12:0] v;
    v = corr(raw, ofs[ch]);
    conv(ch, raw, f);
    rd_chk("integer", ch ? CMD_R2_INT : CMD_R1_INT, v[12:5]);
    rd_chk("fraction", ch ? CMD_R2_FRAC : CMD_R1_FRAC, frac_of(v, f));
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial
  begin
    resetn = 1'b0;
    conv_done = 2'h0;
    conv_raw = 26'h0;
    remote_one_filter_select = FILT_OFF;
    remote_two_filter_select = FILT_OFF;
    ofs[0] = 8'h7f;
    ofs[1] = 8'h80;
    repeat (4) @(negedge ref_clk);
    resetn = 1'b1;
    rd_chk("offset one", CMD_R1_OFS, OFS_RESET);
    rd_chk("offset two", CMD_R2_OFS, OFS_RESET);
    rd_chk("integer one", CMD_R1_INT, RESULT_RESET);
    $display("reset test done");
    // extreme offsets; a write to a result byte must be ignored
    host.wr_cmd(CMD_R1_OFS, ofs[0]);
    host.wr_cmd(CMD_R2_OFS, ofs[1]);
    host.wr_cmd(CMD_R1_INT, 8'h55);
    rd_chk("offset one", CMD_R1_OFS, 8'h7f);
    rd_chk("offset two", CMD_R2_OFS, 8'h80);
    rd_chk("integer kept", CMD_R1_INT, RESULT_RESET);
    rd_chk("unmapped", 8'h00, UNMAPPED_READ);
    $display("offset test done");
    // every filter code on both channels, all fraction bits exercised
    for (int f = 0; f < 4; f++)
    begin
      conv_chk(0, 13'h0a5b + 13'(f), 2'(f));
      conv_chk(1, 13'h1e3f - 13'(f), 2'(f));
    end
    // corrected sums beyond both ends of the unsigned range
    conv_chk(0, 13'h1f00, FILT_ENH);
    conv_chk(1, 13'h0100, FILT_BASIC);
    $display("format test done");
    // fraction frozen by an integer read across a new conversion
    v0 = corr(13'h0123, ofs[0]);
    v1 = corr(13'h1000, ofs[0]);
    conv(0, 13'h0123, FILT_ENH);
    rd_chk("integer old", CMD_R1_INT, v0[12:5]);
    conv(0, 13'h1000, FILT_ENH);
    rd_chk("fraction locked", CMD_R1_FRAC, frac_of(v0, FILT_ENH));
    rd_chk("fraction live", CMD_R1_FRAC, frac_of(v1, FILT_ENH));
    rd_chk("integer new", CMD_R1_INT, v1[12:5]);
    $display("lock test done");
    // second reset in mid-run clears offsets
    @(negedge ref_clk);
    resetn = 1'b0;
    @(negedge ref_clk);
    resetn = 1'b1;
    rd_chk("offset after reset", CMD_R1_OFS, OFS_RESET);
    rd_chk("integer two after reset", CMD_R2_INT, RESULT_RESET);
    // zero offsets pass the raw reading straight through
    ofs[0] = OFS_RESET;
    ofs[1] = OFS_RESET;
    conv_chk(0, 13'h0b6d, FILT_BASIC);
    conv_chk(1, 13'h1fff, FILT_OFF);
    $display("rereset test done");
    print_verdict();
  end
  // watchdog, far beyond the roughly 115 cycles the tests need
  initial
  begin
    #160000;
    n_mismatch++;
    print_verdict();
  end
endmodule // remote_temp_unsigned_result_offset_test
